/* File: core/ppda_defines.svh */
// constants for the program paging and debug arbitration block
`ifndef PPDA_DEFINES_SVH
`define PPDA_DEFINES_SVH
`define PPDA_PAGE_LOW 4'hc
`define PPDA_PAGE_MID 4'hd
`define PPDA_PAGE_TOP 4'hf
`define PPDA_DPS_ADDR 18'h3ff08
`define PPDA_FAM_ADDR 18'h3ff0f
`define PPDA_DPS_EN_BIT 7
`define PPDA_DPS_MASK 8'h8f
`define PPDA_PROGRAM_PAGE_INDEX_RST 8'h00
`define PPDA_DPS_RST 8'h00
`define PPDA_STALL_MAX 8'h80
`define PPDA_WAIT_SAT 8'hff
// family code value is arbitrary
`define PPDA_FAMILY_CODE 8'h5a
`endif

/* File: core/ppda_pkg.sv */
// types for the program paging and debug arbitration block
package ppda_pkg;
  typedef enum logic [1:0] {
    PPDA_IDLE = 2'b00,
    PPDA_ISSUE = 2'b01,
    PPDA_ANSWER = 2'b11
  } ppda_state_type;
  typedef struct packed {
    logic we;
    logic [17:0] addr;
    logic [7:0] wdata;
  } ppda_req_type;
endpackage

/* File: core/ppda_top.sv */
// address translation, page registers and cpu/debug memory arbiter
// Behaviour
// - the low four bits of the program page index pick the page seen at local 0x8000-0xBFFF.
// - a far call or return write of the program page index lands at the next edge.
// - local 0x0000-0x3FFF always maps to global page 0xC.
// - local 0x4000-0x7FFF always maps to global page 0xD.
// - one access at a time, and the cpu wins when both ask together unless the debug access has stalled past the limit.
// - a debug access stalled more than 128 cycles is served ahead of the cpu.
// - the block raises no interrupt.
// - bit 7 of the debug page select turns paging on for debug accesses.
// - debug register commands are never paged.
// - bits 3-0 of the debug page select give the page for paged debug accesses at local 0x8000-0xBFFF.
// - the debug page select is read and written only by the debug unit while unsecured.
// - while the debug unit is active an 8-bit read-only family code reads at its location.
`timescale 1ns/1ps
`include "ppda_defines.svh"
module ppda_top import ppda_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CPU_REQ,
  input wire logic CPU_WE,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [7:0] CPU_WDATA,
  output logic CPU_ACK,
  output logic [7:0] CPU_RDATA,
  input wire logic PAGE_WE,
  input wire logic PAGE_CALL_WE,
  input wire logic [7:0] PAGE_WDATA,
  output logic [7:0] PAGE_Q,
  input wire logic DBG_ACTIVE,
  input wire logic SECURED,
  input wire logic DBG_REQ,
  input wire logic DBG_WE,
  input wire logic DBG_REG_CMD,
  input wire logic [17:0] DBG_ADDR,
  input wire logic [7:0] DBG_WDATA,
  output logic DBG_ACK,
  output logic [7:0] DBG_RDATA,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [17:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA
);

  // fixed pages below the window, page register inside it, top page fixed
  function automatic logic [17:0] ppda_xlate(input logic [15:0] a, input logic [3:0] pg);
    logic [3:0] p;
    p = pg;
    case (a[15:14])
      2'b00: p = `PPDA_PAGE_LOW;
      2'b01: p = `PPDA_PAGE_MID;
      2'b10: p = pg;
      default: p = `PPDA_PAGE_TOP;
    endcase
    return {p, a[13:0]};
  endfunction

  ppda_state_type state_q, state_d;
  ppda_req_type mem_q, mem_d;
  logic mem_req_q, mem_req_d;
  logic owner_q, owner_d;
  logic internal_q, internal_d;
  logic cpu_ack_q, cpu_ack_d;
  logic dbg_ack_q, dbg_ack_d;
  logic [7:0] cpu_rdata_q, cpu_rdata_d;
  logic [7:0] dbg_rdata_q, dbg_rdata_d;
  logic [7:0] program_page_index_q, program_page_index_d;
  logic [7:0] dps_q, dps_d;
  logic [7:0] wait_q, wait_d;
  logic [17:0] cpu_gaddr, dbg_gaddr;
  logic dbg_paged, dbg_hit, dbg_urgent, idle, grant_cpu, grant_dbg;
  logic [7:0] int_rdata;

  // translation and arbitration decisions
  always_comb begin
    cpu_gaddr = ppda_xlate(CPU_ADDR, program_page_index_q[3:0]);
    dbg_paged = dps_q[`PPDA_DPS_EN_BIT] && !DBG_REG_CMD;
    dbg_gaddr = dbg_paged ? ppda_xlate(DBG_ADDR[15:0], dps_q[3:0]) : DBG_ADDR;
    dbg_hit = (dbg_gaddr == `PPDA_DPS_ADDR) || (DBG_ACTIVE && (dbg_gaddr == `PPDA_FAM_ADDR));
    dbg_urgent = wait_q > `PPDA_STALL_MAX;
    idle = state_q == PPDA_IDLE;
    grant_dbg = idle && DBG_REQ && (dbg_urgent || !CPU_REQ);
    grant_cpu = idle && CPU_REQ && !grant_dbg;
  end

  // answer from inside the block for debug register hits
  always_comb begin
    int_rdata = 8'h00;
    if (mem_q.addr == `PPDA_DPS_ADDR && !SECURED) begin
      int_rdata = dps_q;
    end else if (mem_q.addr == `PPDA_FAM_ADDR) begin
      int_rdata = `PPDA_FAMILY_CODE;
    end
  end

  // next state of the access sequencer and registers
  always_comb begin
    state_d = state_q;
    mem_d = mem_q;
    mem_req_d = 1'b0;
    owner_d = owner_q;
    internal_d = internal_q;
    cpu_rdata_d = cpu_rdata_q;
    dbg_rdata_d = dbg_rdata_q;
    program_page_index_d = program_page_index_q;
    dps_d = dps_q;
    wait_d = wait_q;
    case (state_q)
      PPDA_IDLE: begin
        if (grant_cpu || grant_dbg) begin
          state_d = PPDA_ISSUE;
        end
      end
      PPDA_ISSUE: state_d = PPDA_ANSWER;
      PPDA_ANSWER: state_d = PPDA_IDLE;
      default: state_d = PPDA_IDLE;
    endcase
    if (grant_cpu) begin
      mem_req_d = 1'b1;
      mem_d = '{we: CPU_WE, addr: cpu_gaddr, wdata: CPU_WDATA};
      owner_d = 1'b0;
      internal_d = 1'b0;
    end
    if (grant_dbg) begin
      mem_req_d = !dbg_hit;
      mem_d = '{we: DBG_WE, addr: dbg_gaddr, wdata: DBG_WDATA};
      owner_d = 1'b1;
      internal_d = dbg_hit;
    end
    // read data is caught while the access is on the memory port
    if (state_q == PPDA_ISSUE) begin
      if (owner_q) begin
        dbg_rdata_d = internal_q ? int_rdata : MEM_RDATA;
      end else begin
        cpu_rdata_d = MEM_RDATA;
      end
    end
    // only a debug access reaches the page select, and only unsecured
    if (state_q == PPDA_ISSUE && owner_q && internal_q && mem_q.we && !SECURED &&
        mem_q.addr == `PPDA_DPS_ADDR) begin
      dps_d = mem_q.wdata & `PPDA_DPS_MASK;
    end
    // both cpu paths write at the edge, so the page is in place before the next fetch
    if (PAGE_CALL_WE || PAGE_WE) begin
      program_page_index_d = {4'h0, PAGE_WDATA[3:0]};
    end
    // stall counter saturates so a long stall never wraps back below the limit
    if (grant_dbg || !DBG_REQ || (!idle && owner_q)) begin
      wait_d = 8'h00;
    end else if (wait_q != `PPDA_WAIT_SAT) begin
      wait_d = wait_q + 8'h01;
    end
    cpu_ack_d = (state_q == PPDA_ISSUE) && !owner_q;
    dbg_ack_d = (state_q == PPDA_ISSUE) && owner_q;
  end

  // registers only
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= PPDA_IDLE;
      mem_q <= '0;
      mem_req_q <= 1'b0;
      owner_q <= 1'b0;
      internal_q <= 1'b0;
      cpu_ack_q <= 1'b0;
      dbg_ack_q <= 1'b0;
      cpu_rdata_q <= 8'h00;
      dbg_rdata_q <= 8'h00;
      program_page_index_q <= `PPDA_PROGRAM_PAGE_INDEX_RST;
      dps_q <= `PPDA_DPS_RST;
      wait_q <= 8'h00;
    end else begin
      state_q <= state_d;
      mem_q <= mem_d;
      mem_req_q <= mem_req_d;
      owner_q <= owner_d;
      internal_q <= internal_d;
      cpu_ack_q <= cpu_ack_d;
      dbg_ack_q <= dbg_ack_d;
      cpu_rdata_q <= cpu_rdata_d;
      dbg_rdata_q <= dbg_rdata_d;
      program_page_index_q <= program_page_index_d;
      dps_q <= dps_d;
      wait_q <= wait_d;
    end
  end

  // no interrupt output exists on this block
  assign CPU_ACK = cpu_ack_q;
  assign CPU_RDATA = cpu_rdata_q;
  assign DBG_ACK = dbg_ack_q;
  assign DBG_RDATA = dbg_rdata_q;
  assign PAGE_Q = program_page_index_q;
  assign MEM_REQ = mem_req_q;
  assign MEM_WE = mem_q.we;
  assign MEM_ADDR = mem_q.addr;
  assign MEM_WDATA = mem_q.wdata;

  a_window_page_map: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_cpu && CPU_ADDR[15:14] == 2'b10 |=>
      MEM_REQ && MEM_ADDR == {$past(program_page_index_q[3:0]), $past(CPU_ADDR[13:0])})
    else $error("window access used wrong page");
  a_page_write_lands: assert property (@(posedge CLOCK) disable iff (!RST_N)
    PAGE_CALL_WE |=> PAGE_Q == {4'h0, $past(PAGE_WDATA[3:0])})
    else $error("page index write not complete next cycle");
  a_low_fixed_page: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_cpu && CPU_ADDR[15:14] == 2'b00 |=> MEM_ADDR[17:14] == 4'hc)
    else $error("low region not on page c");
  a_mid_fixed_page: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_cpu && CPU_ADDR[15:14] == 2'b01 |=> MEM_ADDR[17:14] == 4'hd)
    else $error("middle region not on page d");
  a_cpu_wins_tie: assert property (@(posedge CLOCK) disable iff (!RST_N)
    idle && CPU_REQ && DBG_REQ && wait_q <= 8'h80 |=> !owner_q ##1 CPU_ACK && !DBG_ACK)
    else $error("cpu lost a tie");
  a_one_at_a_time: assert property (@(posedge CLOCK) disable iff (!RST_N)
    MEM_REQ |=> !MEM_REQ [*2])
    else $error("accesses overlapped");
  a_stalled_debug_first: assert property (@(posedge CLOCK) disable iff (!RST_N)
    idle && DBG_REQ && wait_q > 8'h80 |=> owner_q ##1 DBG_ACK)
    else $error("stalled debug access not served");
  a_debug_paged: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_dbg && dps_q[7] && !DBG_REG_CMD && DBG_ADDR[15:14] == 2'b10 && !dbg_hit |=>
      MEM_ADDR == {$past(dps_q[3:0]), $past(DBG_ADDR[13:0])})
    else $error("paged debug access translated wrongly");
  a_regcmd_unpaged: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_dbg && DBG_REG_CMD |=> mem_q.addr == $past(DBG_ADDR))
    else $error("register command was paged");
  a_secured_no_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SECURED && $stable(SECURED) |-> $stable(dps_q))
    else $error("page select changed while secured");
  a_family_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    grant_dbg && DBG_ACTIVE && dbg_gaddr == `PPDA_FAM_ADDR |=>
      !MEM_REQ ##1 DBG_RDATA == `PPDA_FAMILY_CODE)
    else $error("family code not returned");

endmodule // ppda_top

/* File: verification/ppda_mem_model.sv */
// memory model on the far side of the arbiter's memory port
`timescale 1ns/1ps
module ppda_mem_model (
  input wire logic CLOCK,
  input wire logic MEM_REQ,
  input wire logic [17:0] MEM_ADDR,
  output logic [7:0] MEM_RDATA
);
  logic [7:0] last_q = 8'h00;
  // answers only in the request cycle; otherwise it shows a moving pattern, so stale data fails
  assign MEM_RDATA = MEM_REQ ? (MEM_ADDR[7:0] ^ MEM_ADDR[15:8]) : ~last_q;
  // plain always so the declaration initialiser is not a second writer of an always_ff variable
  always @(posedge CLOCK) begin
    last_q <= MEM_RDATA;
  end
endmodule // ppda_mem_model

/* File: verification/tb_top.sv */
// self-checking bench for program paging and cpu/debug arbitration
`timescale 1ns/1ps
`include "ppda_defines.svh"
module tb_top;
  typedef struct packed {
    logic [3:0] f; // debug, write, register command, memory expected
    logic [17:0] a;
    logic [7:0] wd;
    logic [17:0] ga;
    logic [7:0] rd;
  } ppda_row_type;
  logic clock = 1'b0, rst_n = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0;
  logic page_we = 1'b0, page_call_we = 1'b0, dbg_active = 1'b1, secured = 1'b0;
  logic dbg_req = 1'b0, dbg_we = 1'b0, dbg_reg_cmd = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [17:0] dbg_addr = 18'h00000;
  logic [7:0] cpu_wdata = 8'h00, page_wdata = 8'h00, dbg_wdata = 8'h00;
  logic cpu_ack, dbg_ack, mem_req, mem_we;
  logic [7:0] cpu_rdata, page_q, dbg_rdata, mem_wdata, mem_rdata;
  logic [17:0] mem_addr;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  // ordinary accesses with the global address and data each must give
  ppda_row_type rows [14] = '{
    '{4'h1, 18'h01234, 8'h00, 18'h31234, 8'h00}, '{4'h1, 18'h05678, 8'h00, 18'h35678, 8'h00},
    '{4'h1, 18'h09abc, 8'h00, 18'h15abc, 8'h00}, '{4'h1, 18'h0bfff, 8'h00, 18'h17fff, 8'h00},
    '{4'h5, 18'h08000, 8'h77, 18'h14000, 8'h00}, '{4'h1, 18'h0c001, 8'h00, 18'h3c001, 8'h00},
    '{4'hc, 18'h3ff08, 8'hf3, 18'h00000, 8'h00}, '{4'h8, 18'h3ff08, 8'h00, 18'h00000, 8'h83},
    '{4'h9, 18'h09abc, 8'h00, 18'h0dabc, 8'h00}, '{4'hb, 18'h09abc, 8'h00, 18'h09abc, 8'h00},
    '{4'hc, 18'h3ff0f, 8'h00, 18'h00000, 8'h00},
    '{4'h8, 18'h3ff0f, 8'h00, 18'h00000, `PPDA_FAMILY_CODE},
    '{4'hc, 18'h3ff08, 8'h03, 18'h00000, 8'h00}, '{4'h9, 18'h09abc, 8'h00, 18'h09abc, 8'h00}};
  ppda_top DUT (.CLOCK(clock), .RST_N(rst_n), .CPU_REQ(cpu_req), .CPU_WE(cpu_we),
    .CPU_ADDR(cpu_addr), .CPU_WDATA(cpu_wdata), .CPU_ACK(cpu_ack), .CPU_RDATA(cpu_rdata),
    .PAGE_WE(page_we), .PAGE_CALL_WE(page_call_we), .PAGE_WDATA(page_wdata), .PAGE_Q(page_q),
    .DBG_ACTIVE(dbg_active), .SECURED(secured), .DBG_REQ(dbg_req), .DBG_WE(dbg_we),
    .DBG_REG_CMD(dbg_reg_cmd), .DBG_ADDR(dbg_addr), .DBG_WDATA(dbg_wdata), .DBG_ACK(dbg_ack),
    .DBG_RDATA(dbg_rdata), .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
  ppda_mem_model mem (.CLOCK(clock), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
    .MEM_RDATA(mem_rdata));
  always #25 clock = ~clock;
  function automatic logic [7:0] pat(input logic [17:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one whole access; request held until the ack edge, dropped in the cycle after
  task automatic access(input logic [3:0] f, input logic [17:0] a, input logic [7:0] wd,
      input logic [17:0] ga, input logic [7:0] rd);
    int k;
    logic seen;
    seen = 1'b0;
    @(negedge clock);
    if (f[3]) begin
      {dbg_req, dbg_we, dbg_reg_cmd, dbg_addr, dbg_wdata} = {1'b1, f[2], f[1], a, wd};
    end else begin
      {cpu_req, cpu_we, cpu_addr, cpu_wdata} = {1'b1, f[2], a[15:0], wd};
    end
    for (k = 0; k < 8; k++) begin
      @(negedge clock);
      if (mem_req === 1'b1) begin
        seen = 1'b1;
        check("mem_addr", mem_addr, ga);
        check("mem_we", mem_we, f[2]);
        if (f[2]) check("mem_wdata", mem_wdata, wd);
      end
      if ((f[3] ? dbg_ack : cpu_ack) === 1'b1) break;
    end
    check("ack_cycle", 18'(k), 18'h00001);
    check("mem_req_seen", seen, f[0]);
    if (!f[2]) check("rdata", f[3] ? dbg_rdata : cpu_rdata, f[0] ? pat(ga) : rd);
    @(negedge clock);
    dbg_req = 1'b0;
    cpu_req = 1'b0;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #(50 * 3000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    check("page_q_rst", page_q, 8'h00);
    check("mem_req_rst", mem_req, 1'h0);
    // normal page write; only the index nibble is kept
    page_wdata = 8'hf5;
    page_we = 1'b1;
    @(negedge clock);
    page_we = 1'b0;
    check("page_q", page_q, 8'h05);
    foreach (rows[i]) access(rows[i].f, rows[i].a, rows[i].wd, rows[i].ga, rows[i].rd);
    // far call path: the very next access already sees the new page
    page_wdata = 8'h0a;
    page_call_we = 1'b1;
    @(negedge clock);
    page_call_we = 1'b0;
    access(4'h1, 18'h08010, 8'h00, 18'h28010, 8'h00);
    // secured: page select write ignored, read gives zero
    secured = 1'b1;
    access(4'hc, 18'h3ff08, 8'h8a, 18'h00000, 8'h00);
    access(4'h8, 18'h3ff08, 8'h00, 18'h00000, 8'h00);
    secured = 1'b0;
    access(4'h8, 18'h3ff08, 8'h00, 18'h00000, 8'h03);
    // debug unit inactive: the family location falls through to memory
    dbg_active = 1'b0;
    access(4'h9, 18'h3ff0f, 8'h00, 18'h3ff0f, 8'h00);
    dbg_active = 1'b1;
    // tie goes to the cpu, then a cpu that never lets go starves debug only so long
    @(negedge clock);
    cpu_addr = 16'h1234;
    dbg_addr = 18'h2a5c3;
    cpu_req = 1'b1;
    dbg_req = 1'b1;
    for (n = 0; n < 200 && dbg_ack !== 1'b1; n++) begin
      @(negedge clock);
      if (n == 0) check("tie_addr", mem_addr, 18'h31234);
    end
    check("stall_wait", 18'(n >= 128 && n <= 136), 18'h00001);
    check("stall_rdata", dbg_rdata, pat(18'h2a5c3));
    @(negedge clock);
    dbg_req = 1'b0;
    while (cpu_ack !== 1'b1) @(negedge clock);
    @(negedge clock);
    cpu_req = 1'b0;
    repeat (3) @(negedge clock);
    // reset in mid-run: page index and page select both fall back to their reset values
    rst_n = 1'b0;
    @(negedge clock);
    check("page_q_mid_rst", page_q, `PPDA_PROGRAM_PAGE_INDEX_RST);
    check("acks_mid_rst", {cpu_ack, dbg_ack, mem_req}, 3'h0);
    rst_n = 1'b1;
    access(4'h8, 18'h3ff08, 8'h00, 18'h00000, `PPDA_DPS_RST);
    access(4'h9, 18'h09abc, 8'h00, 18'h09abc, 8'h00);
    tally_and_finish();
  end
endmodule // tb_top
